// *** for_map.svh ***
// Bit positions, reset values, sequence counts and word widths for the
// offset readback and retransmit block. Definitions only.
`ifndef FOR_MAP_SVH
`define FOR_MAP_SVH
// Bit positions inside the synchronised pin vector
`define FOR_SYNC_W 7
`define FOR_B_REN 0
`define FOR_B_LD 1
`define FOR_B_MARK 2
`define FOR_B_RT 3
`define FOR_B_MRS 4
`define FOR_B_PRS 5
`define FOR_B_FIRST_WORD_PASSTHROUGH 6
// Offset readback sequence lengths, in enabled reads
`define FOR_SEQ_ONE 3'h2
`define FOR_SEQ_TWO 3'h4
`define FOR_SEQ_THREE 3'h6
// Reset values
`define FOR_OFS_PTR_RST 3'h0
`define FOR_SYNC_RST 7'h3b // Idle pin levels; mark and strap low
// Output word widths in bits
`define FOR_W36 36
`define FOR_W18 18
`define FOR_W9 9
`endif

// *** for_pkg.sv ***
// Types shared by the offset readback and retransmit block.
// Assumes for_map.svh is on the include path.
package for_pkg;
	// Output bus width selection
	typedef enum logic [1:0] {
		FOR_OW36 = 2'h0,
		FOR_OW18 = 2'h1,
		FOR_OW9 = 2'h2
	} for_ow_type;
	// Retransmit state, one-hot
	typedef enum logic [2:0] {
		FOR_RT_IDLE = 3'h1,
		FOR_RT_MARKED = 3'h2,
		FOR_RT_SETUP = 3'h4
	} for_rt_type;
endpackage : for_pkg

// *** for_read_ctrl.sv ***
// Read side of a FIFO: offset register readback and retransmit from mark.
// Assumes read-side pins arrive asynchronously; write port, offsets and
// width straps come from logic already on clk.
// What this block does
// - One-word offsets: two reads, then wrap
// - Two-word offsets: four reads, then wrap
// - Deep 9-bit: six reads, then wrap
// - Offset readback only with both strobes low
// - Readback pauses and resumes at next word
// - Offset readback overwrites output data word
// - Readback works in both timing modes
// - Full reset rewinds offset pointer; partial keeps
// - Standard: mark with empty flag high enters
// - Passthrough: mark with ready low enters
// - Mark low leaves retransmit mode
// - Latest mark replaces earlier mark
// - Retransmit low rewinds read pointer to mark
// - Standard: empty flag low during setup
// - Standard: empty flag rises edge after retransmit high
// - Standard: every replayed word needs read enable
// - Passthrough: marked word loads without enable
// - Passthrough: later words need read enable
// - Writes never pass the marked location
`timescale 1ns/1ns
`include "for_map.svh"
module for_read_ctrl
	import for_pkg::*;
#(
	parameter int DW = 36,
	parameter int AW = 6,
	parameter int OFS_W = 27
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic readEnableN,
	input wire logic offsetAccessN,
	input wire logic markIn,
	input wire logic retransmitN,
	input wire logic fullResetN,
	input wire logic softResetN,
	input wire logic firstWordPassthrough,
	input wire for_ow_type outWidth,
	input wire logic deepVariant,
	input wire logic [OFS_W-1:0] emptyOffset,
	input wire logic [OFS_W-1:0] fullOffset,
	input wire logic writeValid,
	input wire logic [DW-1:0] writeData,
	output logic writeReady,
	output logic [DW-1:0] readDataOut,
	output logic emptyFlagN,
	output logic outputReadyN,
	output logic retransmitActive
);
	localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

	typedef struct packed {
		logic [`FOR_SYNC_W-1:0] syncA;
		logic [`FOR_SYNC_W-1:0] syncB;
		logic first_word_passthrough;
		logic [2:0] ofsPtr;
		logic [AW:0] rdPtr;
		logic [AW:0] wrPtr;
		logic [AW:0] markPtr;
		for_rt_type rt;
		logic [DW-1:0] dataOut;
		logic emptyN;
		logic readyN;
	} for_state_type;

	for_state_type st_r;
	for_state_type st_nxt;
	logic [DW-1:0] mem [0:(1<<AW)-1];

	logic renN;
	logic ldN;
	logic mark;
	logic rtN;
	logic mrsN;
	logic prsN;
	logic live;
	logic ofsRd;
	logic rtHit;
	logic wrAccept;
	logic [2:0] seqLen;
	logic [2:0] half;
	logic [DW-1:0] ofsWord;
	logic [DW-1:0] memRd;
	logic [DW-1:0] memMark;
	logic [AW:0] rdPrev;
	logic [AW:0] used;

	// Slice one output word from an offset value
	function automatic logic [DW-1:0] ofsPart(
		input logic [OFS_W-1:0] v,
		input logic [2:0] k,
		input for_ow_type ow
	);
		logic [DW-1:0] wide;
		logic [DW-1:0] mask;
		int sh;
		wide = DW'(v);
		sh = (ow == FOR_OW9) ? `FOR_W9 : (ow == FOR_OW18) ? `FOR_W18 : `FOR_W36;
		mask = (sh >= DW) ? '1 : ((DW'(1) << sh) - DW'(1));
		ofsPart = (wide >> (int'(k) * sh)) & mask;
	endfunction : ofsPart

	// Pin levels after the second synchroniser stage
	assign renN = st_r.syncB[`FOR_B_REN];
	assign ldN = st_r.syncB[`FOR_B_LD];
	assign mark = st_r.syncB[`FOR_B_MARK];
	assign rtN = st_r.syncB[`FOR_B_RT];
	assign mrsN = st_r.syncB[`FOR_B_MRS];
	assign prsN = st_r.syncB[`FOR_B_PRS];
	assign live = mrsN && prsN;

	// Sequence length per width and depth variant
	always_comb begin
		case (outWidth)
			FOR_OW18: seqLen = deepVariant ? `FOR_SEQ_TWO : `FOR_SEQ_ONE;
			FOR_OW9: seqLen = deepVariant ? `FOR_SEQ_THREE : `FOR_SEQ_TWO;
			default: seqLen = `FOR_SEQ_ONE;
		endcase
	end
	assign half = seqLen >> 1;

	assign ofsRd = live && !renN && !ldN;
	// Empty half of the pointer range first, then full half
	assign ofsWord = (st_r.ofsPtr < half) ?
		ofsPart(emptyOffset, st_r.ofsPtr, outWidth) :
		ofsPart(fullOffset, st_r.ofsPtr - half, outWidth);

	assign memRd = mem[st_r.rdPtr[AW-1:0]];
	assign memMark = mem[st_r.markPtr[AW-1:0]];
	assign rdPrev = st_r.rdPtr - (AW+1)'(1);
	assign rtHit = live && mark && !rtN && (st_r.rt != FOR_RT_IDLE);

	// fill counted from the mark while retransmitting
	assign used = st_r.wrPtr - ((st_r.rt != FOR_RT_IDLE) ? st_r.markPtr : st_r.rdPtr);
	assign writeReady = live && (used < DEPTH);
	assign wrAccept = writeValid && writeReady;

	// Next-state logic for the whole read side
	always_comb begin
		st_nxt = st_r;
		st_nxt.syncA = {firstWordPassthrough, softResetN, fullResetN,
			retransmitN, markIn, offsetAccessN, readEnableN};
		st_nxt.syncB = st_r.syncA;
		if (!mrsN) begin
			st_nxt.ofsPtr = `FOR_OFS_PTR_RST;
			st_nxt.first_word_passthrough = st_r.syncB[`FOR_B_FIRST_WORD_PASSTHROUGH];
			st_nxt.rdPtr = '0;
			st_nxt.wrPtr = '0;
			st_nxt.markPtr = '0;
			st_nxt.rt = FOR_RT_IDLE;
			st_nxt.dataOut = '0;
		end else if (!prsN) begin
			st_nxt.rdPtr = '0;
			st_nxt.wrPtr = '0;
			st_nxt.markPtr = '0;
			st_nxt.rt = FOR_RT_IDLE;
			st_nxt.dataOut = '0;
		end else begin
			if (wrAccept) begin
				st_nxt.wrPtr = st_r.wrPtr + (AW+1)'(1);
			end
			// pointer holds while either strobe is high
			if (ofsRd) begin
				st_nxt.dataOut = ofsWord;
				st_nxt.ofsPtr = (st_r.ofsPtr + 3'h1 >= seqLen) ? 3'h0 : st_r.ofsPtr + 3'h1;
			end else if (st_r.rt == FOR_RT_SETUP || rtHit) begin
				// Reads held off while the replay is set up
			end else if (!st_r.first_word_passthrough) begin
				if (!renN && st_r.rdPtr != st_r.wrPtr) begin
					st_nxt.dataOut = memRd;
					st_nxt.rdPtr = st_r.rdPtr + (AW+1)'(1);
				end
			end else if (st_r.readyN || !renN) begin
				if (st_r.rdPtr != st_r.wrPtr) begin
					st_nxt.dataOut = memRd;
					st_nxt.rdPtr = st_r.rdPtr + (AW+1)'(1);
					st_nxt.readyN = 1'b0;
				end else begin
					st_nxt.readyN = 1'b1;
				end
			end
			// Retransmit sequencing
			case (st_r.rt)
				FOR_RT_IDLE: begin
					// record the word in the output register
					if (mark && (st_r.first_word_passthrough ? !st_r.readyN : st_r.emptyN)) begin
						st_nxt.rt = FOR_RT_MARKED;
						st_nxt.markPtr = rdPrev;
					end
				end
				FOR_RT_MARKED: begin
					if (!mark) begin
						st_nxt.rt = FOR_RT_IDLE;
					end else if (!rtN) begin
						st_nxt.rt = FOR_RT_SETUP;
						st_nxt.rdPtr = st_r.markPtr;
					end
				end
				FOR_RT_SETUP: begin
					if (!mark) begin
						st_nxt.rt = FOR_RT_IDLE;
					end else if (!rtN) begin
						st_nxt.rdPtr = st_r.markPtr;
					end else begin
						st_nxt.rt = FOR_RT_MARKED;
						if (st_r.first_word_passthrough) begin
							st_nxt.dataOut = memMark;
							st_nxt.rdPtr = st_r.markPtr + (AW+1)'(1);
							st_nxt.readyN = 1'b0;
						end
					end
				end
				default: st_nxt.rt = FOR_RT_IDLE;
			endcase
		end
		st_nxt.emptyN = !st_nxt.first_word_passthrough && live && (st_nxt.rt != FOR_RT_SETUP) &&
			(st_nxt.rdPtr != st_nxt.wrPtr);
		// ready held high through setup and resets
		if (!st_nxt.first_word_passthrough || !live || st_nxt.rt == FOR_RT_SETUP) begin
			st_nxt.readyN = 1'b1;
		end
	end

	// State register; the strap is caught while full reset is low
	always_ff @(posedge clk) begin
		if (rst) begin
			// Idle pin levels, so no false mark is seen right after reset
			st_r.syncA <= `FOR_SYNC_RST;
			st_r.syncB <= `FOR_SYNC_RST;
			st_r.first_word_passthrough <= 1'b0;
			st_r.ofsPtr <= `FOR_OFS_PTR_RST;
			st_r.rdPtr <= '0;
			st_r.wrPtr <= '0;
			st_r.markPtr <= '0;
			st_r.rt <= FOR_RT_IDLE;
			st_r.dataOut <= '0;
			st_r.emptyN <= 1'b0;
			st_r.readyN <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Storage; no reset needed since pointers gate every read
	always_ff @(posedge clk) begin
		if (wrAccept) begin
			mem[st_r.wrPtr[AW-1:0]] <= writeData;
		end
	end

	assign readDataOut = st_r.dataOut;
	assign emptyFlagN = st_r.emptyN;
	assign outputReadyN = st_r.readyN;
	assign retransmitActive = (st_r.rt != FOR_RT_IDLE);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	ofs_wrap_two_a: assert property (ofsRd && seqLen == 3'h2 && st_r.ofsPtr == 3'h1
		|=> st_r.ofsPtr == 3'h0) else $error("offset pointer missed wrap after two");
	ofs_wrap_four_a: assert property (ofsRd && seqLen == 3'h4 && st_r.ofsPtr == 3'h3
		|=> st_r.ofsPtr == 3'h0) else $error("offset pointer missed wrap after four");
	ofs_wrap_six_a: assert property (ofsRd && seqLen == 3'h6 && st_r.ofsPtr == 3'h5
		|=> st_r.ofsPtr == 3'h0) else $error("offset pointer missed wrap after six");
	ofs_data_out_a: assert property (ofsRd |=> readDataOut == $past(ofsWord))
		else $error("offset word not on output");
	ofs_pause_hold_a: assert property (mrsN && !ofsRd |=> $stable(st_r.ofsPtr))
		else $error("offset pointer moved during pause");
	ofs_full_rst_a: assert property (!mrsN |=> st_r.ofsPtr == 3'h0)
		else $error("full reset kept offset pointer");
	mark_entry_a: assert property (live && !st_r.first_word_passthrough && st_r.rt == FOR_RT_IDLE
		&& mark && st_r.emptyN |=> retransmitActive && st_r.markPtr == $past(rdPrev))
		else $error("mark not recorded");
	mark_exit_a: assert property (mrsN && !mark |=> !retransmitActive)
		else $error("retransmit mode kept with mark low");
	rt_rewind_a: assert property (rtHit |=> st_r.rdPtr == $past(st_r.markPtr)
		&& st_r.rt == FOR_RT_SETUP && !emptyFlagN) else $error("rewind failed");
	// marked word loads on retransmit release
	first_word_passthrough_load_a: assert property (live && st_r.first_word_passthrough && st_r.rt == FOR_RT_SETUP
		&& mark && rtN |=> !outputReadyN && readDataOut == $past(memMark))
		else $error("marked word not loaded");
	// no accepted write lands on the marked word
	mark_guard_a: assert property (retransmitActive && wrAccept
		|-> st_r.wrPtr[AW-1:0] != st_r.markPtr[AW-1:0])
		else $error("write allowed over marked data");

	// Passthrough entry, read gating and setup flags, both modes
	// passthrough entry records output word
	mark_first_word_passthrough_entry_a: assert property (live && st_r.first_word_passthrough && st_r.rt == FOR_RT_IDLE
		&& mark && !outputReadyN |=> retransmitActive && st_r.markPtr == $past(rdPrev))
		else $error("passthrough mark not recorded");
	// setup blocks reads in both modes
	setup_flags_a: assert property (st_r.rt == FOR_RT_SETUP
		|-> !emptyFlagN && outputReadyN) else $error("read flag open during setup");
	// flag rises on the edge that ends setup
	flag_release_a: assert property (live && !st_r.first_word_passthrough && st_r.rt == FOR_RT_SETUP
		&& mark && rtN && st_r.rdPtr != st_r.wrPtr |=> emptyFlagN)
		else $error("empty flag stuck after setup");
	std_read_gate_a: assert property (live && !st_r.first_word_passthrough && renN && !rtHit
		|=> $stable(st_r.rdPtr))
		else $error("standard read without enable");
	first_word_passthrough_read_gate_a: assert property (live && st_r.first_word_passthrough && !outputReadyN && renN && rtN
		|=> $stable(st_r.rdPtr)) else $error("passthrough read without enable");

	// Main scenarios reached
	ofs_six_cov: cover property (ofsRd && seqLen == 3'h6 && st_r.ofsPtr == 3'h5);
	prs_pause_cov: cover property (!prsN && mrsN && st_r.ofsPtr != 3'h0);
	rt_std_cov: cover property (!st_r.first_word_passthrough && st_r.rt == FOR_RT_SETUP ##1
		st_r.rt == FOR_RT_MARKED);
	rt_first_word_passthrough_cov: cover property (st_r.first_word_passthrough && st_r.rt == FOR_RT_SETUP ##1 !outputReadyN);
	guard_cov: cover property (retransmitActive && writeValid && !writeReady);
endmodule : for_read_ctrl

// *** for_ctrl_model.sv ***
// Controller model for the read-side pins: enabled reads, mark, retransmit.
// Assumes one bench process calls its tasks and clk runs free.
`timescale 1ns/1ns
module for_ctrl_model (
	input wire logic clk,
	output logic readEnableN,
	output logic offsetAccessN,
	output logic markIn,
	output logic retransmitN,
	output logic issue
);
	// Pins idle inactive from time zero
	initial begin
		readEnableN = 1'b1;
		offsetAccessN = 1'b1;
		markIn = 1'b0;
		retransmitN = 1'b1;
		issue = 1'b0;
	end
	// One enabled read lasting one cycle; issue marks it for the bench
	// idle between reads
	task automatic rd(input logic ld);
		@(negedge clk);
		readEnableN = 1'b0;
		offsetAccessN = ld;
		issue = 1'b1;
		@(negedge clk);
		readEnableN = 1'b1;
		offsetAccessN = 1'b1;
		issue = 1'b0;
		repeat (4) @(negedge clk); // Lets the synchroniser drain first
	endtask : rd
	task automatic mark(input logic v);
		@(negedge clk);
		markIn = v;
		repeat (4) @(negedge clk);
	endtask : mark
	task automatic rt(input logic v);
		@(negedge clk);
		retransmitN = v;
		repeat (4) @(negedge clk);
	endtask : rt
endmodule : for_ctrl_model

// *** fifo_offset_readback_retransmit_test.sv ***
// Self-checking bench for the FIFO read controller.
// Assumes for_map.svh on the include path and for_pkg compiled first.
`timescale 1ns/1ns
module fifo_offset_readback_retransmit_test;
	import for_pkg::*;
	logic clk = 1'b0;
	logic rst;
	logic fullResetN;
	logic softResetN;
	logic firstWordPassthrough;
	for_ow_type outWidth;
	logic deepVariant;
	logic [26:0] emptyOffset;
	logic [26:0] fullOffset;
	logic writeValid;
	logic [35:0] writeData;
	logic writeReady, emptyFlagN, outputReadyN, retransmitActive, issue;
	logic readEnableN, offsetAccessN, markIn, retransmitN;
	logic [35:0] readDataOut;
	logic [35:0] curMask = 36'hfffffffff;
	logic [35:0] expQ[$];
	logic [35:0] w[$];
	logic [2:0] sh = 3'h0;
	int mismatches = 0;
	int total_checks = 0;
	int acc;
	for_ow_type ow[5] = '{FOR_OW36, FOR_OW18, FOR_OW18, FOR_OW9, FOR_OW9};
	logic dp[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	int wd[5] = '{36, 18, 18, 9, 9};
	int sq[5] = '{2, 2, 4, 4, 6};
	always #5 clk = ~clk;
	for_ctrl_model for_ctrl_model_inst (.clk(clk), .readEnableN(readEnableN),
		.offsetAccessN(offsetAccessN), .markIn(markIn), .retransmitN(retransmitN),
		.issue(issue));
	for_read_ctrl for_read_ctrl_inst (.clk(clk), .rst(rst), .readEnableN(readEnableN),
		.offsetAccessN(offsetAccessN), .markIn(markIn), .retransmitN(retransmitN),
		.fullResetN(fullResetN), .softResetN(softResetN),
		.firstWordPassthrough(firstWordPassthrough), .outWidth(outWidth),
		.deepVariant(deepVariant), .emptyOffset(emptyOffset), .fullOffset(fullOffset),
		.writeValid(writeValid), .writeData(writeData), .writeReady(writeReady),
		.readDataOut(readDataOut), .emptyFlagN(emptyFlagN), .outputReadyN(outputReadyN),
		.retransmitActive(retransmitActive));
	task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] ex);
		total_checks++;
		if (seen !== ex) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, seen);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	// Offset word k of a sequence of s words, b bits each, low part first
	function automatic logic [35:0] ofs(input int k, input int s, input int b);
		logic [35:0] v;
		v = (k < s / 2) ? 36'(emptyOffset) : 36'(fullOffset);
		return (v >> ((k % (s / 2)) * b)) & curMask;
	endfunction : ofs
	// Full or partial reset pin, held past the synchroniser
	task automatic pinRst(input logic full);
		@(negedge clk);
		if (full) fullResetN = 1'b0;
		else softResetN = 1'b0;
		repeat (4) @(negedge clk);
		fullResetN = 1'b1;
		softResetN = 1'b1;
		repeat (4) @(negedge clk);
	endtask : pinRst
	task automatic wr(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			writeValid = 1'b1;
			writeData = {i[3:0], $urandom()};
			w.push_back(writeData);
		end
		@(negedge clk);
		writeValid = 1'b0;
		repeat (4) @(negedge clk);
	endtask : wr
	task automatic rdx(input logic [35:0] ex);
		expQ.push_back(ex);
		for_ctrl_model_inst.rd(1'b1);
	endtask : rdx
	// Read results land three edges after the enabled read
	always @(posedge clk) sh <= {sh[1:0], issue};
	always @(negedge clk) begin
		if (sh[2]) begin
			check("readDataOut", readDataOut & curMask, expQ.pop_front());
		end
	end
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
	initial begin
		// Inputs start idle; offsets are random below
		rst = 1'b1;
		fullResetN = 1'b1;
		softResetN = 1'b1;
		firstWordPassthrough = 1'b0;
		outWidth = FOR_OW36;
		deepVariant = 1'b0;
		writeValid = 1'b0;
		writeData = 36'h0;
		void'($urandom(32'hdc8d));
		emptyOffset = 27'($urandom());
		fullOffset = 27'($urandom());
		repeat (5) @(negedge clk);
		rst = 1'b0;
		// Readback per width and depth, one read past the end to see the wrap
		for (int c = 0; c < 5; c++) begin
			outWidth = ow[c];
			deepVariant = dp[c];
			pinRst(1'b1); // full reset rewinds pointer
			curMask = (36'h1 << wd[c]) - 36'h1;
			for (int k = 0; k <= sq[c]; k++) begin
				if (c == 4 && k == 2) pinRst(1'b0); // pause over partial reset
				expQ.push_back(ofs(k % sq[c], sq[c], wd[c]));
				for_ctrl_model_inst.rd(1'b0);
			end
		end
		// Standard mode retransmit, then a second mark
		outWidth = FOR_OW36;
		deepVariant = 1'b0;
		curMask = 36'hfffffffff;
		pinRst(1'b1);
		wr(12);
		rdx(w[0]);
		rdx(w[1]);
		for_ctrl_model_inst.mark(1'b1);
		check("retransmitActive", retransmitActive, 36'h1);
		rdx(w[2]);
		rdx(w[3]);
		for_ctrl_model_inst.rt(1'b0);
		check("emptyFlagN", emptyFlagN, 36'h0);
		for_ctrl_model_inst.rt(1'b1);
		check("emptyFlagN", emptyFlagN, 36'h1);
		check("readDataOut", readDataOut, w[3]);
		rdx(w[1]);
		rdx(w[2]);
		for_ctrl_model_inst.mark(1'b0);
		check("retransmitActive", retransmitActive, 36'h0);
		for_ctrl_model_inst.mark(1'b1);
		rdx(w[3]);
		for_ctrl_model_inst.rt(1'b0);
		for_ctrl_model_inst.rt(1'b1);
		rdx(w[2]);
		// Writes stop when the marked word would be overwritten
		acc = 0;
		repeat (80) begin
			@(negedge clk);
			writeValid = 1'b1;
			#1;
			if (writeReady === 1'b1) acc++;
		end
		@(negedge clk);
		writeValid = 1'b0;
		// Room left from the mark: depth less the ten words still kept
		check("acceptedWrites", 36'(acc), 36'h36);
		// Passthrough mode; mark drops first so the refill cannot enter early
		for_ctrl_model_inst.mark(1'b0);
		check("retransmitActive", retransmitActive, 36'h0);
		firstWordPassthrough = 1'b1;
		w.delete();
		pinRst(1'b1);
		wr(12);
		check("outputReadyN", outputReadyN, 36'h0);
		for_ctrl_model_inst.mark(1'b1);
		check("retransmitActive", retransmitActive, 36'h1);
		rdx(w[1]);
		for_ctrl_model_inst.rt(1'b0);
		check("outputReadyN", outputReadyN, 36'h1);
		for_ctrl_model_inst.rt(1'b1);
		check("outputReadyN", outputReadyN, 36'h0);
		check("readDataOut", readDataOut, w[0]);
		rdx(w[1]);
		expQ.push_back(36'(emptyOffset));
		for_ctrl_model_inst.rd(1'b0);
		summarize();
	end
endmodule : fifo_offset_readback_retransmit_test
